// *** pin_mode_and_channel_gating_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_mode_and_channel_gating_bench;
  localparam int unsigned FILT = 8;
  logic        mclk;
  logic        rst;
  wire         psel, penable, pwrite, pready, pslverr, serial_out_req, serial_out_oe;
  wire         parallel_cmd_in_a, parallel_cmd_in_b, idle_pin, external_reset_pin;
  wire         channel_disable_pin, pwm_gen_a, pwm_gen_b, vbatt_uv_det_en, vddio_uv_det_en;
  wire [1:0]   op_mode;
  wire [3:0]   pstrb;
  wire [7:0]   paddr, channel_drive;
  wire [31:0]  pwdata, prdata;
  int          error_cnt;
  int          num_checks;
  logic [31:0] rd_v;
  logic        rd_e;

  pmg_core #(.FILT_CYC(FILT)) pmg_core_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .parallel_cmd_in_a, .parallel_cmd_in_b,
    .idle_pin, .external_reset_pin, .channel_disable_pin, .pwm_gen_a, .pwm_gen_b,
    .serial_out_req, .serial_out_oe, .channel_drive, .vbatt_uv_det_en, .vddio_uv_det_en,
    .op_mode);
  pmg_host #(.FILT_CYC(FILT)) pmg_host_i (.mclk, .prdata, .pready, .pslverr, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .parallel_cmd_in_a, .parallel_cmd_in_b,
    .idle_pin, .external_reset_pin, .channel_disable_pin, .pwm_gen_a, .pwm_gen_b,
    .serial_out_req);

  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    pmg_host_i.apb(1'h1, a, d, rd_v, rd_e);
  endtask
  task rd(input logic [7:0] a);
    pmg_host_i.apb(1'h0, a, 32'h0, rd_v, rd_e);
  endtask
  // Read, expecting no bus error and the given word
  task rchk(input string n, input logic [7:0] a, input logic [31:0] x);
    rd(a);
    chk("bus error", 32'(rd_e), 32'h0);
    chk(n, rd_v, x);
  endtask

  task t_sleep;
    wt(FILT + 10);
    chk("mode", 32'(op_mode), 32'h0);
    chk("uv", 32'(vbatt_uv_det_en | vddio_uv_det_en), 32'h0);
    chk("serial oe", 32'(serial_out_oe), 32'h0);
    rd(pmg_pkg::ROUTE_A_OFS);
    chk("sleep err", 32'(rd_e), 32'h1);
    chk("sleep data", rd_v, 32'h0);
    pmg_host_i.idle(1'h1);
    chk("mode", 32'(op_mode), 32'h1);
    chk("uv on", 32'(vbatt_uv_det_en & vddio_uv_det_en), 32'h1);
    chk("serial oe", 32'(serial_out_oe), 32'h1);
    $display("t_sleep done");
  endtask
  // Pins held open while still masked must not gate
  task t_route;
    rchk("route a", pmg_pkg::ROUTE_A_OFS, 32'h4);
    rchk("route b", pmg_pkg::ROUTE_B_OFS, 32'h8);
    rchk("pin cfg", pmg_pkg::PIN_CFG_OFS, 32'h0);
    pmg_host_i.pins(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    wt(5);
    chk("drive", 32'(channel_drive), 32'h4);
    pmg_host_i.pins(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    wt(5);
    chk("drive", 32'(channel_drive), 32'hc);
    rchk("status", pmg_pkg::IN_STATUS_OFS, 32'hf);
    $display("t_route done");
  endtask
  task t_remap;
    wr(pmg_pkg::ROUTE_A_OFS, 32'h81);
    wr(pmg_pkg::ROUTE_B_OFS, 32'h0);
    wr(pmg_pkg::OUT_CMD_OFS, 32'h10);
    wr(pmg_pkg::PWM_ROUTE_OFS, 32'h2000);
    pmg_host_i.pins(1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1);
    wt(5);
    chk("drive", 32'(channel_drive), 32'hb1);
    pmg_host_i.pins(1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1);
    wt(5);
    chk("drive", 32'(channel_drive), 32'h30);
    $display("t_remap done");
  endtask
  task t_dis;
    wr(pmg_pkg::PIN_CFG_OFS, 32'h1);
    wt(5);
    chk("drive", 32'(channel_drive), 32'h0);
    pmg_host_i.pins(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    wt(5);
    chk("drive", 32'(channel_drive), 32'h30);
    rchk("status", pmg_pkg::IN_STATUS_OFS, 32'ha);
    $display("t_dis done");
  endtask
  // Unmasking while the reset pin is low clears every register
  task t_external_reset_pin;
    wr(pmg_pkg::PIN_CFG_OFS, 32'h3);
    wt(5);
    rchk("route a", pmg_pkg::ROUTE_A_OFS, 32'h4);
    rchk("pin cfg", pmg_pkg::PIN_CFG_OFS, 32'h0);
    chk("drive", 32'(channel_drive), 32'h8);
    $display("t_external_reset_pin done");
  endtask
  task t_limp;
    pmg_host_i.pins(1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    pmg_host_i.idle(1'h0);
    chk("mode", 32'(op_mode), 32'h2);
    chk("drive", 32'(channel_drive), 32'h4);
    rchk("status", pmg_pkg::IN_STATUS_OFS, 32'h11);
    rchk("mode status", pmg_pkg::MODE_STATUS_OFS, 32'h6);
    wr(pmg_pkg::OUT_CMD_OFS, 32'h40);
    wt(3);
    chk("drive", 32'(channel_drive), 32'h44);
    pmg_host_i.pins(1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    wt(6);
    chk("mode", 32'(op_mode), 32'h0);
    chk("uv", 32'(vbatt_uv_det_en | vddio_uv_det_en), 32'h0);
    chk("drive", 32'(channel_drive), 32'h0);
    rd(pmg_pkg::OUT_CMD_OFS);
    chk("sleep err", 32'(rd_e), 32'h1);
    pmg_host_i.idle(1'h1);
    rchk("out cmd", pmg_pkg::OUT_CMD_OFS, 32'h0);
    $display("t_limp done");
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run is under two hundred cycles; the margin covers a hung transfer
  initial begin
    repeat (4000) @(posedge mclk);
    error_cnt++;
    finish_test;
  end

  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst = 1'h1;
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    t_sleep;
    t_route;
    t_remap;
    t_dis;
    t_external_reset_pin;
    t_limp;
    finish_test;
  end
endmodule
`default_nettype wire

// *** pmg_core.sv ***
// How it works
// - Reset routes input a to 2, b to 3
// - One writable route register per parallel input
// - Channel request ORs command, PWM and inputs
// - Input pin levels readable in input status
// - Input monitoring stays live in limp-home
// - Idle low, input high: limp-home, default channels
// - Idle and both inputs low: sleep
// - Sleep entry resets every software register
// - Sleep turns both undervoltage detectors off
// - Sleep refuses transfers, serial output stays off
// - Unmasked low reset pin: one-cycle reset and channels off, then masked again
// - Open reset pin reads as asserted
// - Reset pin ignored until software unmasks it
// - Unmasked high disable pin forces channels off
// - Low disable pin lets channels follow requests
// - Disable pin ignored until software unmasks it
// - Disable pin level readable in input status
// - Open disable pin reads as asserted
`timescale 1ns/10ps
`default_nettype none
module pmg_core #(
  parameter int unsigned NUM_CH   = pmg_pkg::NUM_CH,
  parameter int unsigned FILT_CYC = pmg_pkg::IDLE_FILT_CYC
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [pmg_pkg::ADDR_W-1:0] paddr,
  input  wire logic [pmg_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [pmg_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Control pins
  input  wire logic                      parallel_cmd_in_a,
  input  wire logic                      parallel_cmd_in_b,
  input  wire logic                      idle_pin,
  input  wire logic                      external_reset_pin,
  input  wire logic                      channel_disable_pin,
  // Internal PWM generators, same clock
  input  wire logic                      pwm_gen_a,
  input  wire logic                      pwm_gen_b,
  // Serial output enable request from the serial engine
  input  wire logic                      serial_out_req,
  output logic                           serial_out_oe,
  // Channel drives and supply monitor enables
  output logic      [NUM_CH-1:0]         channel_drive,
  output logic                           vbatt_uv_det_en,
  output logic                           vddio_uv_det_en,
  output logic      [1:0]                op_mode
);

  // Software registers
  logic [NUM_CH-1:0]   out_cmd;
  logic [NUM_CH-1:0]   input_a_route_reg;
  logic [NUM_CH-1:0]   input_b_route_reg;
  logic                disable_pin_unmask;
  logic                reset_pin_unmask;
  logic [NUM_CH-1:0]   pwm_a_route;
  logic [NUM_CH-1:0]   pwm_b_route;

  // Synchronised pins
  logic                in_a_s;
  logic                in_b_s;
  logic                idle_s;
  logic                xres_s;
  logic                dis_s;
  logic                idle_f;

  // Mode state
  pmg_pkg::pmg_mode_t  mode;
  pmg_pkg::pmg_mode_t  next_mode;

  // Decode and control wires
  logic                setup_ph;
  logic                access_ph;
  logic                in_sleep;
  logic                sleep_entry;
  logic                xres_active;
  logic                dis_active;
  logic                reg_clear;
  logic                wr_ok;
  logic                addr_hit;
  logic [NUM_CH-1:0]   route_in;
  logic [NUM_CH-1:0]   route_pwm;
  logic [NUM_CH-1:0]   limp_req;
  logic [NUM_CH-1:0]   drive_req;
  logic [NUM_CH-1:0]   next_drive;
  logic [pmg_pkg::DATA_W-1:0] rd_word;
  logic                err_q;
  // One select per register, shared by the decode and the write enables
  logic                sel_out_cmd;
  logic                sel_route_a;
  logic                sel_route_b;
  logic                sel_pin_cfg;
  logic                sel_pwm_route;
  logic                sel_in_status;
  logic                sel_mode_status;
  logic                wr_lane0;
  logic                in_limp;

  // Pin synchronisers; reset and disable pins come up asserted
  // Coming up asserted mirrors the pulls, so an open pin never passes
  // through a deasserted level while the synchronisers fill
  pmg_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h0)
  ) u_sync_cmd (
    .mclk      (mclk),
    .rst       (rst),
    .pin_async ({idle_pin, parallel_cmd_in_b, parallel_cmd_in_a}),
    .pin_sync  ({idle_s, in_b_s, in_a_s})
  );

  pmg_sync #(
    .WIDTH   (2),
    .RST_VAL (2'h2)
  ) u_sync_safe (
    .mclk      (mclk),
    .rst       (rst),
    .pin_async ({channel_disable_pin, external_reset_pin}),
    .pin_sync  ({dis_s, xres_s})
  );

  // Idle level only counts once it has held for the filter time
  pmg_idle_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_idle_filt (
    .mclk      (mclk),
    .rst       (rst),
    .level_in  (idle_s),
    .level_out (idle_f)
  );

  // Selects which channels a one-bit source drives
  function automatic logic [NUM_CH-1:0] fan(input logic src, input logic [NUM_CH-1:0] map);
    fan = src ? map : '0;
  endfunction

  // Byte-lane merge for a register narrower than a word
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  lanes);
    merge16 = old_v;
    if (lanes[0]) begin
      merge16[7:0] = new_v[7:0];
    end
    if (lanes[1]) begin
      merge16[15:8] = new_v[15:8];
    end
  endfunction

  // Mode selection from the filtered idle level and the inputs
  always_comb begin
    if (idle_f) begin
      next_mode = pmg_pkg::PMG_ACTIVE;
    end else if (in_a_s || in_b_s) begin
      next_mode = pmg_pkg::PMG_LIMP;
    end else begin
      next_mode = pmg_pkg::PMG_SLEEP;
    end
  end

  // Mode register; power-up settles to sleep until idle or inputs say otherwise
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode <= pmg_pkg::PMG_SLEEP;
    end else begin
      mode <= next_mode;
    end
  end

  // Mode-derived controls
  assign in_sleep    = mode == pmg_pkg::PMG_SLEEP;
  assign in_limp     = mode == pmg_pkg::PMG_LIMP;
  assign sleep_entry = next_mode == pmg_pkg::PMG_SLEEP && !in_sleep;
  // Mask bits hold the pins off until software opens them
  assign xres_active = reset_pin_unmask && !xres_s;
  assign dis_active  = disable_pin_unmask && dis_s;
  // Sleep entry, staying in sleep and an external reset all clear the registers
  // Limitation: the clear also masks the reset pin again, so a pin held low
  // resets the registers for one cycle only; software must unmask it again
  assign reg_clear   = sleep_entry || in_sleep || xres_active;

  // APB decode; zero wait states, error on unmapped address or in sleep
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign addr_hit  = sel_out_cmd || sel_route_a || sel_route_b || sel_pin_cfg ||
                     sel_pwm_route || sel_in_status || sel_mode_status;
  assign wr_ok     = access_ph && pwrite && !err_q && !reg_clear;
  assign wr_lane0  = wr_ok && pstrb[0];   // Most registers sit in lane 0 only
  assign pready    = access_ph;
  assign pslverr   = access_ph && err_q;

  // Register selects from the byte address
  assign sel_out_cmd     = paddr == pmg_pkg::OUT_CMD_OFS;
  assign sel_route_a     = paddr == pmg_pkg::ROUTE_A_OFS;
  assign sel_route_b     = paddr == pmg_pkg::ROUTE_B_OFS;
  assign sel_pin_cfg     = paddr == pmg_pkg::PIN_CFG_OFS;
  assign sel_pwm_route   = paddr == pmg_pkg::PWM_ROUTE_OFS;
  assign sel_in_status   = paddr == pmg_pkg::IN_STATUS_OFS;
  assign sel_mode_status = paddr == pmg_pkg::MODE_STATUS_OFS;

  // Read multiplexer; status is live, including in limp-home
  always_comb begin
    rd_word = '0;
    unique case (paddr)
      pmg_pkg::OUT_CMD_OFS:   rd_word[NUM_CH-1:0] = out_cmd;
      pmg_pkg::ROUTE_A_OFS:   rd_word[NUM_CH-1:0] = input_a_route_reg;
      pmg_pkg::ROUTE_B_OFS:   rd_word[NUM_CH-1:0] = input_b_route_reg;
      pmg_pkg::PIN_CFG_OFS: begin
        rd_word[pmg_pkg::DIS_UNMASK_BIT] = disable_pin_unmask;
        rd_word[pmg_pkg::RES_UNMASK_BIT] = reset_pin_unmask;
      end
      pmg_pkg::PWM_ROUTE_OFS: rd_word[2*NUM_CH-1:0] = {pwm_b_route, pwm_a_route};
      pmg_pkg::IN_STATUS_OFS: begin
        rd_word[pmg_pkg::ST_IN_A_BIT] = in_a_s;
        rd_word[pmg_pkg::ST_IN_B_BIT] = in_b_s;
        rd_word[pmg_pkg::ST_DIS_BIT]  = dis_s;
        rd_word[pmg_pkg::ST_IDLE_BIT] = idle_f;
        rd_word[pmg_pkg::ST_RES_BIT]  = xres_s;
      end
      pmg_pkg::MODE_STATUS_OFS: begin
        rd_word[pmg_pkg::MS_MODE_LSB +: 2] = mode;
        rd_word[pmg_pkg::MS_UV_BIT]        = !in_sleep;
        rd_word[pmg_pkg::MS_XRES_BIT]      = xres_active;
      end
      default: rd_word = '0;
    endcase
  end

  // Read data and error are captured in the setup cycle, shown in the access cycle
  // Capturing at setup keeps prdata on a flop yet costs no wait state
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= '0;
      err_q  <= 1'b0;
    end else if (setup_ph) begin
      prdata <= (pwrite || in_sleep) ? '0 : rd_word;
      err_q  <= !addr_hit || in_sleep;
    end
  end

  // Serial command bits
  always_ff @(posedge mclk) begin
    if (rst || reg_clear) begin
      out_cmd <= pmg_pkg::OUT_CMD_RST;
    end else if (wr_lane0 && sel_out_cmd) begin
      out_cmd <= pwdata[NUM_CH-1:0];
    end
  end

  // Input routing registers, one per parallel input
  always_ff @(posedge mclk) begin
    if (rst || reg_clear) begin
      input_a_route_reg <= pmg_pkg::ROUTE_A_RST;
      input_b_route_reg <= pmg_pkg::ROUTE_B_RST;
    end else if (wr_lane0) begin
      if (sel_route_a) begin
        input_a_route_reg <= pwdata[NUM_CH-1:0];
      end
      if (sel_route_b) begin
        input_b_route_reg <= pwdata[NUM_CH-1:0];
      end
    end
  end

  // Pin unmask bits; cleared by any register reset, so the pins fall masked again
  always_ff @(posedge mclk) begin
    if (rst || reg_clear) begin
      {reset_pin_unmask, disable_pin_unmask} <= pmg_pkg::PIN_CFG_RST;
    end else if (wr_lane0 && sel_pin_cfg) begin
      disable_pin_unmask <= pwdata[pmg_pkg::DIS_UNMASK_BIT];
      reset_pin_unmask   <= pwdata[pmg_pkg::RES_UNMASK_BIT];
    end
  end

  // PWM generator routing, two byte lanes
  always_ff @(posedge mclk) begin
    if (rst || reg_clear) begin
      {pwm_b_route, pwm_a_route} <= pmg_pkg::PWM_ROUTE_RST;
    end else if (wr_ok && sel_pwm_route) begin
      {pwm_b_route, pwm_a_route} <= merge16({pwm_b_route, pwm_a_route},
                                            pwdata[15:0], pstrb[1:0]);
    end
  end

  // Request OR of every drive source
  assign route_in  = fan(in_a_s, input_a_route_reg) | fan(in_b_s, input_b_route_reg);
  assign route_pwm = fan(pwm_gen_a, pwm_a_route) | fan(pwm_gen_b, pwm_b_route);
  // Limp-home uses the fixed default map, independent of software state
  assign limp_req  = in_limp ?
                     (fan(in_a_s, pmg_pkg::ROUTE_A_RST) | fan(in_b_s, pmg_pkg::ROUTE_B_RST)) :
                     '0;
  assign drive_req = out_cmd | route_pwm | route_in | limp_req;

  // Gates sit after the OR so they override even limp-home
  // Sleep gates here too, so a stale command cannot reach the outputs
  assign next_drive = (dis_active || xres_active || in_sleep) ? '0 : drive_req;

  // Registered channel drives
  always_ff @(posedge mclk) begin
    if (rst) begin
      channel_drive <= '0;
    end else begin
      channel_drive <= next_drive;
    end
  end

  // Undervoltage detectors off in sleep to save current
  // Taken from next_mode so the enables switch on the same edge as the mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      vbatt_uv_det_en <= 1'b0;
      vddio_uv_det_en <= 1'b0;
    end else begin
      vbatt_uv_det_en <= next_mode != pmg_pkg::PMG_SLEEP;
      vddio_uv_det_en <= next_mode != pmg_pkg::PMG_SLEEP;
    end
  end

  // Serial output stays released in sleep whatever chip select does
  // Combinational, so the pin is already released in the first sleep cycle
  assign serial_out_oe = serial_out_req && !in_sleep;
  assign op_mode       = mode;

endmodule
`default_nettype wire

// *** pmg_core_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of modes, gating and bus refusal
module pmg_chk #(
  parameter int unsigned NUM_CH   = 8,
  parameter int unsigned FILT_CYC = 8
) (
  input wire logic                        mclk,
  input wire logic                        rst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [pmg_pkg::ADDR_W-1:0]  paddr,
  input wire logic [pmg_pkg::DATA_W-1:0]  prdata,
  input wire logic                        pslverr,
  input wire logic                        parallel_cmd_in_a,
  input wire logic                        parallel_cmd_in_b,
  input wire logic                        idle_pin,
  input wire logic                        external_reset_pin,
  input wire logic                        channel_disable_pin,
  input wire logic                        serial_out_oe,
  input wire logic [NUM_CH-1:0]           channel_drive,
  input wire logic                        vbatt_uv_det_en,
  input wire logic                        vddio_uv_det_en,
  input wire logic [1:0]                  op_mode
);
  int   cnt_sleep;
  int   cnt_limp;
  int   cnt_a;
  int   cnt_dis;
  logic rd_sta;

  // Run lengths of pin conditions, so settling time is not guessed per cycle
  always_ff @(posedge mclk) cnt_sleep <= (rst || idle_pin || parallel_cmd_in_a
    || parallel_cmd_in_b) ? 0 : cnt_sleep + 1;
  always_ff @(posedge mclk) cnt_limp <= (rst || idle_pin || !parallel_cmd_in_a
    || channel_disable_pin || !external_reset_pin) ? 0 : cnt_limp + 1;
  always_ff @(posedge mclk) cnt_a <= (rst || !parallel_cmd_in_a) ? 0 : cnt_a + 1;
  always_ff @(posedge mclk) cnt_dis <= (rst || !channel_disable_pin) ? 0 : cnt_dis + 1;

  // Access phase of a status read
  assign rd_sta = psel && penable && !pwrite && paddr == pmg_pkg::IN_STATUS_OFS;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_uv;
    vbatt_uv_det_en == (op_mode != 2'h0) && vddio_uv_det_en == vbatt_uv_det_en;
  endproperty
  a_uv: assert property (p_uv) else $error("uv enables wrong");
  property p_oe;
    op_mode == 2'h0 && $past(op_mode) == 2'h0 |-> !serial_out_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("serial output on in sleep");
  property p_err;
    psel && penable && op_mode == 2'h0 && $past(op_mode) == 2'h0 |-> pslverr && prdata == '0;
  endproperty
  a_err: assert property (p_err) else $error("sleep access not refused");
  property p_sleep;
    cnt_sleep >= FILT_CYC + 8 |-> op_mode == 2'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  property p_limp;
    cnt_limp >= FILT_CYC + 8 |-> op_mode == 2'h2 && channel_drive[2];
  endproperty
  a_limp: assert property (p_limp) else $error("no limp drive");
  property p_sdrv;
    op_mode == 2'h0 && $past(op_mode) == 2'h0 |-> channel_drive == '0;
  endproperty
  a_sdrv: assert property (p_sdrv) else $error("drive in sleep");
  property p_sta;
    rd_sta && op_mode == 2'h2 && $past(op_mode) == 2'h2 && cnt_a >= 5 |-> prdata[0];
  endproperty
  a_sta: assert property (p_sta) else $error("input level lost in limp");
  property p_dis;
    rd_sta && op_mode != 2'h0 && $past(op_mode) != 2'h0 && cnt_dis >= 5 |-> prdata[2];
  endproperty
  a_dis: assert property (p_dis) else $error("disable level lost");
endmodule

bind pmg_core pmg_chk #(.NUM_CH(NUM_CH), .FILT_CYC(FILT_CYC)) pmg_chk_i (.mclk, .rst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pslverr, .parallel_cmd_in_a, .parallel_cmd_in_b,
  .idle_pin, .external_reset_pin, .channel_disable_pin, .serial_out_oe, .channel_drive,
  .vbatt_uv_det_en, .vddio_uv_det_en, .op_mode);
`default_nettype wire

// *** pmg_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host controller: drives the pins and masters the register bus
module pmg_host #(
  parameter int unsigned FILT_CYC = 8
) (
  input  wire logic        mclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  output logic             parallel_cmd_in_a,
  output logic             parallel_cmd_in_b,
  output logic             idle_pin,
  output logic             external_reset_pin,
  output logic             channel_disable_pin,
  output logic             pwm_gen_a,
  output logic             pwm_gen_b,
  output logic             serial_out_req
);
  // Open pins show their pulls: reset pin low, disable pin high
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    {parallel_cmd_in_a, parallel_cmd_in_b, idle_pin, pwm_gen_a, pwm_gen_b} = 5'h00;
    external_reset_pin = 1'h0;
    channel_disable_pin = 1'h1;
    serial_out_req = 1'h1;
  end

  // One transfer; released lines take inverted values so stale data cannot match
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (!pready) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  // Pin levels change together just after an edge
  task pins(input logic a, input logic b, input logic d, input logic n,
            input logic pa, input logic pb);
    @(posedge mclk);
    parallel_cmd_in_a <= a;
    parallel_cmd_in_b <= b;
    channel_disable_pin <= d;
    external_reset_pin <= n;
    pwm_gen_a <= pa;
    pwm_gen_b <= pb;
  endtask

  // New idle level is held past the filter and synchroniser delay
  task idle(input logic v);
    @(posedge mclk);
    idle_pin <= v;
    repeat (FILT_CYC + 8) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** pmg_idle_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
// Accepts a new level only after it has been stable for FILT_CYC cycles
module pmg_idle_filter #(
  parameter int unsigned FILT_CYC = 2000
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic level_in,
  output logic      level_out
);

  localparam int unsigned CNT_W = $clog2(FILT_CYC + 1);

  logic [CNT_W-1:0] stable_cnt;
  logic             differs;
  logic             expired;

  assign differs = level_in != level_out;
  assign expired = stable_cnt >= CNT_W'(FILT_CYC - 1);

  // Glitches shorter than the window restart the count
  always_ff @(posedge mclk) begin
    if (rst) begin
      stable_cnt <= '0;
      level_out  <= 1'b0;
    end else if (!differs) begin
      stable_cnt <= '0;
    end else if (expired) begin
      stable_cnt <= '0;
      level_out  <= level_in;
    end else begin
      stable_cnt <= stable_cnt + CNT_W'(1);
    end
  end

endmodule
`default_nettype wire

// *** pmg_pkg.sv ***
// Shared constants for the pin mode and channel gating block
package pmg_pkg;

  // Channel count and APB geometry
  localparam int unsigned NUM_CH    = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;

  // Register byte offsets
  localparam logic [7:0] OUT_CMD_OFS     = 8'h00;
  localparam logic [7:0] ROUTE_A_OFS     = 8'h04;
  localparam logic [7:0] ROUTE_B_OFS     = 8'h08;
  localparam logic [7:0] PIN_CFG_OFS     = 8'h0c;
  localparam logic [7:0] PWM_ROUTE_OFS   = 8'h10;
  localparam logic [7:0] IN_STATUS_OFS   = 8'h14;
  localparam logic [7:0] MODE_STATUS_OFS = 8'h18;

  // Reset values
  localparam logic [7:0]  OUT_CMD_RST   = 8'h00;
  localparam logic [7:0]  ROUTE_A_RST   = 8'h04;   // Input a drives channel 2
  localparam logic [7:0]  ROUTE_B_RST   = 8'h08;   // Input b drives channel 3
  localparam logic [1:0]  PIN_CFG_RST   = 2'h0;
  localparam logic [15:0] PWM_ROUTE_RST = 16'h0000;

  // Field positions in the pin configuration register
  localparam int unsigned DIS_UNMASK_BIT = 0;
  localparam int unsigned RES_UNMASK_BIT = 1;

  // Field positions in the input status register
  localparam int unsigned ST_IN_A_BIT  = 0;
  localparam int unsigned ST_IN_B_BIT  = 1;
  localparam int unsigned ST_DIS_BIT   = 2;
  localparam int unsigned ST_IDLE_BIT  = 3;
  localparam int unsigned ST_RES_BIT   = 4;

  // Field positions in the mode status register
  localparam int unsigned MS_MODE_LSB  = 0;
  localparam int unsigned MS_UV_BIT    = 2;
  localparam int unsigned MS_XRES_BIT  = 3;

  // Idle filter time and clock rate
  localparam int unsigned IDLE_FILT_NS = 100000;
  localparam int unsigned MCLK_NS      = 50;
  // Longest time: round down, at least one cycle
  localparam int unsigned IDLE_FILT_CYC =
    (IDLE_FILT_NS / MCLK_NS) < 1 ? 1 : (IDLE_FILT_NS / MCLK_NS);

  // Operating modes
  typedef enum logic [1:0] {
    PMG_SLEEP,
    PMG_ACTIVE,
    PMG_LIMP
  } pmg_mode_t;

endpackage

// *** pmg_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser for asynchronous pins
module pmg_sync #(
  parameter int unsigned        WIDTH = 1,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta     <= RST_VAL;
      pin_sync <= RST_VAL;
    end else begin
      meta     <= pin_async;
      pin_sync <= meta;
    end
  end

endmodule
`default_nettype wire
